// [src/eic_defs.svh]
// Register offsets, field positions, reset values and timing counts of the edge interrupt controller
`ifndef EIC_DEFS_SVH
`define EIC_DEFS_SVH
// Byte offsets on the register bus
`define EIC_OFS_ENA1  8'h00
`define EIC_OFS_ENA2  8'h04
`define EIC_OFS_FLG1  8'h08
`define EIC_OFS_FLG2  8'h0C
`define EIC_OFS_WKFLG 8'h10
`define EIC_OFS_WKEDG 8'h14
`define EIC_OFS_WKFN  8'h18
`define EIC_OFS_RPEDG 8'h1C
`define EIC_OFS_RPFN  8'h20
`define EIC_OFS_EVSEL 8'h24
`define EIC_OFS_CPU   8'h28
// Enable bit positions in the first enable register
`define EIC_ENA_P0   0
`define EIC_ENA_P1   1
`define EIC_ENA_EVC  2
`define EIC_ENA_WAKE 3
`define EIC_ENA_DT   4
// Flag positions in the first request flag register
`define EIC_FLG_P0  0
`define EIC_FLG_P1  1
`define EIC_FLG_EVC 2
`define EIC_FLG_DT  3
// Implemented bits and reset values
`define EIC_MSK_ENA1 8'h1F
`define EIC_MSK_FLG1 8'h0F
`define EIC_RST_BYTE 8'h00
`define EIC_RST_MASK 1'b1
`define EIC_COND_I   7
// Entry sequence lengths in states, one state per clock
`define EIC_ST_STACK 4
`define EIC_ST_VECT  2
`define EIC_ST_FETCH 4
`define EIC_ST_PROC  4
`define EIC_N_STACK  3'(`EIC_ST_STACK)
`define EIC_N_VECT   3'(`EIC_ST_VECT)
`define EIC_N_FETCH  3'(`EIC_ST_FETCH)
`define EIC_N_PROC   3'(`EIC_ST_PROC)
// Vector numbering and bus answers
`define EIC_VEC_FIRST 8'h04
`define EIC_RESP_OK   2'h0
`define EIC_RESP_ERR  2'h2
`endif

// [src/eic_pkg.sv]
// Types shared by the edge interrupt controller
package eic_pkg;
  typedef enum logic [5:0] {
    EIC_IDLE = 6'h01,
    EIC_WAIT = 6'h02,
    EIC_STK  = 6'h04,
    EIC_VEC  = 6'h08,
    EIC_IFT  = 6'h10,
    EIC_INP  = 6'h20
  } eic_state_t;
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } eic_stk_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] idx;
  } eic_req_t;
endpackage

// [src/eic_top.sv]
// Edge interrupt controller: pin edges, flags, masking, priority and exception entry
`timescale 1ns/100ps
`include "eic_defs.svh"
module eic_top #(
  parameter int NPER = 8,
  parameter int AW   = 8
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // AXI4-Lite write channels
  input  wire logic [AW-1:0]     awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [AW-1:0]     araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Interrupt pins, asynchronous
  input  wire logic [7:0]        wakeup_pins_n,
  input  wire logic              request_pin_0_n,
  input  wire logic              request_pin_1_n,
  input  wire logic              event_counter_request_pin,
  // Peripheral and sleep requests, one-cycle pulses
  input  wire logic [NPER-1:0]   periph_req,
  input  wire logic              sleep_dt_req,
  // Processor core
  input  wire logic              core_done,
  input  wire logic              core_rte,
  input  wire logic [7:0]        rte_cond,
  input  wire logic [7:0]        cond_flags,
  input  wire logic [15:0]       core_sp,
  input  wire logic [15:0]       next_pc,
  output eic_pkg::eic_stk_t      stk_wr,
  output logic                   pc_load,
  output logic [15:0]            pc_vec,
  output logic                   i_mask,
  output eic_pkg::eic_req_t      req_out
);

  localparam int NSRC = 5 + NPER;

  // Peripheral flags live in one byte register
  generate
    if (NPER < 1 || NPER > 8 || AW < 8) begin : g_chk
      $error("eic_top: NPER must be 1..8 and AW at least 8");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave handshake
  logic            awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic            awf_r, wf_r;
  logic [7:0]      wad_r;
  logic [7:0]      wdt_r;
  logic            wst_r;
  logic [1:0]      bresp_r, rresp_r, rresp_nxt;
  logic [31:0]     rdata_r, rdata_nxt;
  wire             aw_hs  = awvalid & awready_r;
  wire             w_hs   = wvalid & wready_r;
  wire             ar_hs  = arvalid & arready_r;
  wire             wr_go  = awf_r & wf_r & ~bvalid_r;
  wire             awf_nxt = aw_hs | (awf_r & ~wr_go);
  wire             wf_nxt  = w_hs | (wf_r & ~wr_go);
  wire             bv_nxt  = wr_go | (bvalid_r & ~bready);
  wire             rv_nxt  = ar_hs | (rvalid_r & ~rready);

  // Readies drop while a beat is held so the master keeps its payload
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      rvalid_r  <= 1'b0;
      awf_r     <= 1'b0;
      wf_r      <= 1'b0;
    end else begin
      awready_r <= ~awf_nxt & ~bv_nxt;
      wready_r  <= ~wf_nxt & ~bv_nxt;
      arready_r <= ~rv_nxt;
      bvalid_r  <= bv_nxt;
      rvalid_r  <= rv_nxt;
      awf_r     <= awf_nxt;
      wf_r      <= wf_nxt;
    end
  end

  // Held write beat; only byte lane 0 carries register bits
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wad_r <= 8'h00;
      wdt_r <= 8'h00;
      wst_r <= 1'b0;
    end else begin
      if (aw_hs) wad_r <= awaddr[7:0];
      if (w_hs) wdt_r <= wdata[7:0];
      if (w_hs) wst_r <= wstrb[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  wire wr_b0   = wr_go & wst_r;
  wire s_ena1  = wr_b0 && wad_r == `EIC_OFS_ENA1;
  wire s_ena2  = wr_b0 && wad_r == `EIC_OFS_ENA2;
  wire s_flg1  = wr_b0 && wad_r == `EIC_OFS_FLG1;
  wire s_flg2  = wr_b0 && wad_r == `EIC_OFS_FLG2;
  wire s_wkflg = wr_b0 && wad_r == `EIC_OFS_WKFLG;
  wire s_wkedg = wr_b0 && wad_r == `EIC_OFS_WKEDG;
  wire s_wkfn  = wr_b0 && wad_r == `EIC_OFS_WKFN;
  wire s_rpedg = wr_b0 && wad_r == `EIC_OFS_RPEDG;
  wire s_rpfn  = wr_b0 && wad_r == `EIC_OFS_RPFN;
  wire s_evsel = wr_b0 && wad_r == `EIC_OFS_EVSEL;
  wire s_cpu   = wr_b0 && wad_r == `EIC_OFS_CPU;
  wire w_map   = wad_r[7:2] <= `EIC_OFS_CPU >> 2 && wad_r[1:0] == 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0] ena1_r, ena2_r, wkedg_r, wkfn_r;
  logic [1:0] rpedg_r, rpfn_r, evsel_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ena1_r  <= `EIC_RST_BYTE;
      ena2_r  <= `EIC_RST_BYTE;
      wkedg_r <= `EIC_RST_BYTE;
      wkfn_r  <= `EIC_RST_BYTE;
      rpedg_r <= 2'h0;
      rpfn_r  <= 2'h0;
      evsel_r <= 2'h0;
    end else begin
      if (s_ena1) ena1_r <= wdt_r & `EIC_MSK_ENA1;
      if (s_ena2) ena2_r <= wdt_r;
      if (s_wkedg) wkedg_r <= wdt_r;
      if (s_wkfn) wkfn_r <= wdt_r;
      if (s_rpedg) rpedg_r <= wdt_r[1:0];
      if (s_rpfn) rpfn_r <= wdt_r[1:0];
      if (s_evsel) evsel_r <= wdt_r[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [10:0] s1_r, s2_r, prv_r;
  wire  [10:0] raw = {event_counter_request_pin, request_pin_1_n, request_pin_0_n, wakeup_pins_n};
  // A pin outside interrupt mode reads high, so a function change on a low pin is an edge
  wire  [10:0] eff = {s2_r[10], s2_r[9:8] | ~rpfn_r, s2_r[7:0] | ~wkfn_r};
  wire  [10:0] rise = eff & ~prv_r;
  wire  [10:0] fall = ~eff & prv_r;
  wire  [9:0]  esel = {rpedg_r, wkedg_r};
  logic [9:0]  pset;

  // Low-active pins idle high and the event pin idles low, so release shows no false edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_r  <= 11'h3FF;
      s2_r  <= 11'h3FF;
      prv_r <= 11'h3FF;
    end else begin
      s1_r  <= raw;
      s2_r  <= s1_r;
      prv_r <= eff;
    end
  end

  // Each wakeup and request pin picks its edge on its own
  generate
    for (genvar i = 0; i < 10; i++) begin : g_edge
      assign pset[i] = esel[i] ? rise[i] : fall[i];
    end
  endgenerate

  // Event pin: 00 falling, 01 rising, 1x both
  wire ev_edge = evsel_r == 2'h0 ? fall[10] : evsel_r == 2'h1 ? rise[10] : (rise[10] | fall[10]);
  wire ev_set  = ev_edge & ena1_r[`EIC_ENA_EVC];

  ////////////////////////////////////////////////////////////////////////////
  // Request flags: write zero clears, set wins over clear
  logic [7:0] flg1_r, flg2_r, wkflg_r;
  wire  [7:0] flg1_set = 8'({sleep_dt_req, ev_set, pset[9], pset[8]});
  wire  [7:0] flg2_set = 8'(periph_req);
  wire  [7:0] wk_set   = pset[7:0];
  wire  [7:0] flg1_clr = s_flg1 ? ~wdt_r : 8'h00;
  wire  [7:0] flg2_clr = s_flg2 ? ~wdt_r : 8'h00;
  wire  [7:0] wk_clr   = s_wkflg ? ~wdt_r : 8'h00;

  // Acceptance leaves every flag alone; only software clears them
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flg1_r  <= `EIC_RST_BYTE;
      flg2_r  <= `EIC_RST_BYTE;
      wkflg_r <= `EIC_RST_BYTE;
    end else begin
      flg1_r  <= (flg1_set | (flg1_r & ~flg1_clr)) & `EIC_MSK_FLG1;
      flg2_r  <= flg2_set | (flg2_r & ~flg2_clr);
      wkflg_r <= wk_set | (wkflg_r & ~wk_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending requests and priority, lower index wins
  wire [NSRC-1:0] pend = {flg2_r[NPER-1:0] & ena2_r[NPER-1:0],
                          flg1_r[`EIC_FLG_DT] & ena1_r[`EIC_ENA_DT],
                          flg1_r[`EIC_FLG_EVC] & ena1_r[`EIC_ENA_EVC],
                          (|wkflg_r) & ena1_r[`EIC_ENA_WAKE],
                          flg1_r[`EIC_FLG_P1] & ena1_r[`EIC_ENA_P1],
                          flg1_r[`EIC_FLG_P0] & ena1_r[`EIC_ENA_P0]};
  wire            any_p = |pend;

  function automatic logic [7:0] prio(input logic [NSRC-1:0] p);
    logic [7:0] idx;
    idx = 8'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (p[i]) idx = 8'(i);
    end
    return `EIC_VEC_FIRST + idx;
  endfunction

  wire [7:0] win = prio(pend);

  ////////////////////////////////////////////////////////////////////////////
  // Exception entry sequence
  eic_pkg::eic_state_t st_r, st_nxt;
  logic [2:0]          cnt_r, cnt_nxt;
  logic [7:0]          vidx_r;
  logic                i_mask_r, pc_load_r;
  logic [15:0]         pc_vec_r;
  eic_pkg::eic_stk_t   stk_r, stk_nxt;
  eic_pkg::eic_req_t   req_r;
  wire  [2:0]          cnt_inc = cnt_r + 3'd1;

  // Completion wait is the core's; the fixed phases are counted here
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_inc;
    case (st_r)
      eic_pkg::EIC_IDLE: begin
        cnt_nxt = 3'd0;
        if (any_p && !i_mask_r) st_nxt = eic_pkg::EIC_WAIT;
      end
      eic_pkg::EIC_WAIT: begin
        cnt_nxt = 3'd0;
        if (core_done) st_nxt = eic_pkg::EIC_STK;
      end
      eic_pkg::EIC_STK: begin
        if (cnt_r == `EIC_N_STACK - 3'd1) begin
          st_nxt  = eic_pkg::EIC_VEC;
          cnt_nxt = 3'd0;
        end
      end
      eic_pkg::EIC_VEC: begin
        if (cnt_r == `EIC_N_VECT - 3'd1) begin
          st_nxt  = eic_pkg::EIC_IFT;
          cnt_nxt = 3'd0;
        end
      end
      eic_pkg::EIC_IFT: begin
        if (cnt_r == `EIC_N_FETCH - 3'd1) begin
          st_nxt  = eic_pkg::EIC_INP;
          cnt_nxt = 3'd0;
        end
      end
      eic_pkg::EIC_INP: begin
        if (cnt_r == `EIC_N_PROC - 3'd1) begin
          st_nxt  = eic_pkg::EIC_IDLE;
          cnt_nxt = 3'd0;
        end
      end
      default: begin
        st_nxt  = eic_pkg::EIC_IDLE;
        cnt_nxt = 3'd0;
      end
    endcase
  end

  // Return address at SP-2, flags word at SP-4, low address bit forced to zero
  wire [15:0] sp_pc = (core_sp - 16'h0002) & 16'hFFFE;
  wire [15:0] sp_cf = (core_sp - 16'h0004) & 16'hFFFE;
  wire [7:0]  cf_sv = {i_mask_r, cond_flags[6:0]};
  assign stk_nxt.we   = st_nxt == eic_pkg::EIC_STK && !cnt_nxt[0];
  assign stk_nxt.addr = cnt_nxt[1] ? sp_cf : sp_pc;
  assign stk_nxt.data = cnt_nxt[1] ? {cf_sv, 8'h00} : next_pc;
  wire   mask_set = st_r == eic_pkg::EIC_STK && st_nxt == eic_pkg::EIC_VEC;
  wire   go_pc    = st_r == eic_pkg::EIC_INP && st_nxt == eic_pkg::EIC_IDLE;

  // Winner is frozen on entry, so a clear during the wait does not cancel it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r   <= eic_pkg::EIC_IDLE;
      cnt_r  <= 3'd0;
      vidx_r <= 8'h00;
      stk_r  <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      stk_r <= stk_nxt;
      if (st_r == eic_pkg::EIC_IDLE && st_nxt == eic_pkg::EIC_WAIT) vidx_r <= win;
    end
  end

  // Mask bit: entry sets it, return restores it, software may write it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      i_mask_r  <= `EIC_RST_MASK;
      pc_load_r <= 1'b0;
      pc_vec_r  <= 16'h0000;
      req_r     <= '0;
    end else begin
      if (mask_set) i_mask_r <= 1'b1;
      else if (core_rte) i_mask_r <= rte_cond[`EIC_COND_I];
      else if (s_cpu) i_mask_r <= wdt_r[0];
      pc_load_r <= go_pc;
      if (go_pc) pc_vec_r <= 16'({vidx_r, 1'b0});
      req_r.valid <= any_p & ~i_mask_r;
      req_r.idx   <= win;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode and responses
  wire [7:0] ra = araddr[7:0];

  always_comb begin
    rresp_nxt = `EIC_RESP_OK;
    if (ra == `EIC_OFS_ENA1) rdata_nxt = {24'h0, ena1_r};
    else if (ra == `EIC_OFS_ENA2) rdata_nxt = {24'h0, ena2_r};
    else if (ra == `EIC_OFS_FLG1) rdata_nxt = {24'h0, flg1_r};
    else if (ra == `EIC_OFS_FLG2) rdata_nxt = {24'h0, flg2_r};
    else if (ra == `EIC_OFS_WKFLG) rdata_nxt = {24'h0, wkflg_r};
    else if (ra == `EIC_OFS_WKEDG) rdata_nxt = {24'h0, wkedg_r};
    else if (ra == `EIC_OFS_WKFN) rdata_nxt = {24'h0, wkfn_r};
    else if (ra == `EIC_OFS_RPEDG) rdata_nxt = {30'h0, rpedg_r};
    else if (ra == `EIC_OFS_RPFN) rdata_nxt = {30'h0, rpfn_r};
    else if (ra == `EIC_OFS_EVSEL) rdata_nxt = {30'h0, evsel_r};
    else if (ra == `EIC_OFS_CPU) rdata_nxt = {16'h0, vidx_r, 5'h00, st_r != eic_pkg::EIC_IDLE, any_p, i_mask_r};
    else begin
      rdata_nxt = 32'h00000000;
      rresp_nxt = `EIC_RESP_ERR;
    end
  end

  // Answers are captured at the handshake and held until taken
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h00000000;
      rresp_r <= `EIC_RESP_OK;
      bresp_r <= `EIC_RESP_OK;
    end else begin
      if (ar_hs) rdata_r <= rdata_nxt;
      if (ar_hs) rresp_r <= rresp_nxt;
      if (wr_go) bresp_r <= w_map ? `EIC_RESP_OK : `EIC_RESP_ERR;
    end
  end

  // Outputs straight from flops
  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign stk_wr  = stk_r;
  assign pc_load = pc_load_r;
  assign pc_vec  = pc_vec_r;
  assign i_mask  = i_mask_r;
  assign req_out = req_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_wk_edge;
    $fell(eff[0]) && !wkedg_r[0] |=> wkflg_r[0];
  endproperty
  a_wk_edge: assert property (p_wk_edge) else $error("wakeup fall missed");

  property p_rp1_fn;
    $rose(rpfn_r[1]) && !s2_r[9] && !$past(s2_r[9]) && !rpedg_r[1] |=> flg1_r[`EIC_FLG_P1];
  endproperty
  a_rp1_fn: assert property (p_rp1_fn) else $error("pin1 function change missed");

  property p_rp0_fn;
    $fell(rpfn_r[0]) && !s2_r[8] && !$past(s2_r[8]) && rpedg_r[0] |=> flg1_r[`EIC_FLG_P0];
  endproperty
  a_rp0_fn: assert property (p_rp0_fn) else $error("pin0 function change missed");

  property p_wk_hold;
    wkflg_r[0] && !(s_wkflg && !wdt_r[0]) |=> wkflg_r[0];
  endproperty
  a_wk_hold: assert property (p_wk_hold) else $error("wakeup flag lost");

  property p_masked;
    i_mask_r && st_r == eic_pkg::EIC_IDLE |=> st_r == eic_pkg::EIC_IDLE;
  endproperty
  a_masked: assert property (p_masked) else $error("request taken while masked");

  property p_seq;
    st_r == eic_pkg::EIC_WAIT && core_done |=> (st_r == eic_pkg::EIC_STK)[*4] ##1 (st_r == eic_pkg::EIC_VEC)[*2]
      ##1 (st_r == eic_pkg::EIC_IFT)[*4] ##1 (st_r == eic_pkg::EIC_INP)[*4] ##1 pc_load_r;
  endproperty
  a_seq: assert property (p_seq) else $error("entry timing wrong");

  property p_mask_set;
    st_r == eic_pkg::EIC_STK ##1 st_r == eic_pkg::EIC_VEC |-> i_mask_r;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set after push");

  property p_rst;
    $fell(reset) |-> i_mask_r && st_r == eic_pkg::EIC_IDLE;
  endproperty
  a_rst: assert property (p_rst) else $error("not masked after reset");

  property p_even;
    stk_r.we |-> !stk_r.addr[0];
  endproperty
  a_even: assert property (p_even) else $error("odd stack address");

  property p_prio;
    pend[0] |=> req_r.idx == `EIC_VEC_FIRST;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");

  property p_cv_take;
    pc_load_r;
  endproperty
  c_cv_take: cover property (p_cv_take);

  property p_cv_rte;
    core_rte ##1 !i_mask_r;
  endproperty
  c_cv_rte: cover property (p_cv_rte);

  property p_cv_two;
    pend[0] && pend[2];
  endproperty
  c_cv_two: cover property (p_cv_two);

endmodule

// [testbench/eic_core_model.sv]
// Processor core stand-in that reports instruction completion
`timescale 1ns/100ps
module eic_core_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Instruction completion pulse
  output logic      core_done
);
  int left;
  // Instructions take 1 to 13 states, so completion comes at random spacing
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      core_done <= 1'b0;
      left      <= 1;
    end else if (left <= 1) begin
      core_done <= 1'b1;
      left      <= $urandom_range(13, 1);
    end else begin
      core_done <= 1'b0;
      left      <= left - 1;
    end
  end
endmodule

// [testbench/edge_interrupt_controller_test.sv]
// Self-checking bench for the edge interrupt controller
`timescale 1ns/100ps
`include "eic_defs.svh"
module edge_interrupt_controller_test;
  logic              clock, reset, awvalid, awready, wvalid, wready, bvalid, bready, cd;
  logic              arvalid, arready, rvalid, rready, request_pin_0_n, request_pin_1_n;
  logic              event_counter_request_pin, sleep_dt_req, core_done, core_rte, pc_load, i_mask;
  logic [1:0]        bresp, rresp, rs;
  logic [7:0]        awaddr, araddr, wakeup_pins_n, periph_req, rte_cond, cond_flags, x, m, e;
  logic [15:0]       core_sp, next_pc, pc_vec, a;
  logic [31:0]       wdata, rdata, rv;
  eic_pkg::eic_stk_t stk_wr, stq[$];
  eic_pkg::eic_req_t req_out;
  int                mismatches, check_count, n, k, wq[$];

  eic_top i_dut (
    .clock, .reset, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .wakeup_pins_n, .request_pin_0_n, .request_pin_1_n, .event_counter_request_pin, .periph_req,
    .sleep_dt_req, .core_done, .core_rte, .rte_cond, .cond_flags, .core_sp, .next_pc, .stk_wr,
    .pc_load, .pc_vec, .i_mask, .req_out
  );
  eic_core_model i_core (.clock, .reset, .core_done);

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bounded-wait helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic lim(input int c);
    if (n == c) begin
      mismatches++;
      conclude();
    end
  endtask
  // Bus cycles sample ready and valid just after the edge, before the design updates
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    // Ready stays high between transfers so a back-to-back call never lowers and raises it in one step
    rs = bresp;
    lim(50);
  endtask
  task automatic rd(input logic [7:0] ad);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rv = rdata;
    rs = rresp;
    lim(50);
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    rd(ad);
    check(rv, exp);
  endtask
  // Follows one exception entry up to the load of the vector
  task automatic entry(input int vn);
    stq = {};
    wq  = {};
    for (n = 0; n < 80; n++) begin
      cd = core_done;
      @(posedge clock);
      if (stk_wr.we) begin
        if (wq.size() == 0) check(cd, 1);
        stq.push_back(stk_wr);
        wq.push_back(n);
      end
      if (pc_load) break;
    end
    lim(80);
    check(wq.size(), 2);
    if (wq.size() == 2) begin
      check(n - wq[0], 14);
      check(wq[1] - wq[0], 2);
      a = core_sp - 16'h0002;
      check(stq[0].addr, a & 16'hFFFE);
      check(stq[0].data, next_pc);
      a = core_sp - 16'h0004;
      check(stq[1].addr, a & 16'hFFFE);
      check(stq[1].data, {1'b0, cond_flags[6:0], 8'h00});
    end
    check(pc_vec, vn * 2);
    check(i_mask, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Main sequence; pins idle high so enabling a function makes no edge
  initial begin
    {reset, awvalid, wvalid, bready, arvalid, rready, core_rte} = 7'h40;
    {awaddr, araddr, wdata, periph_req, rte_cond, cond_flags, core_sp, next_pc} = '0;
    {sleep_dt_req, event_counter_request_pin} = 2'h0;
    {wakeup_pins_n, request_pin_0_n, request_pin_1_n} = 10'h3FF;
    k = $urandom(66114);
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check(i_mask, 1);
    for (k = 0; k < 'h30; k += 4) begin
      rd(k[7:0]);
      check(rv, k == 'h28);
      check(rs, k == 'h2C ? 2 : 0);
    end
    wr(8'h2C, 1);
    check(rs, 2);
    // Wakeup pins: falling then rising edges, each pin on its own select bit
    e = 8'($urandom) & 8'hFE;
    x = 8'($urandom) & 8'hFE;
    wr(`EIC_OFS_WKEDG, e);
    wr(`EIC_OFS_WKFN, 8'hFF);
    wakeup_pins_n <= x;
    repeat (6) @(posedge clock);
    m = ~x & ~e;
    rchk(`EIC_OFS_WKFLG, m);
    wakeup_pins_n <= 8'hFF;
    repeat (6) @(posedge clock);
    x = ~x;
    rchk(`EIC_OFS_WKFLG, x);
    wr(`EIC_OFS_WKFLG, 8'hFF);
    rchk(`EIC_OFS_WKFLG, x);
    m = 8'($urandom) | 8'h01;
    wr(`EIC_OFS_WKFLG, m);
    x = x & m;
    rchk(`EIC_OFS_WKFLG, x);
    // Request pins: function change while the pin is low acts as an edge
    wr(`EIC_OFS_ENA1, 8'h03);
    for (k = 0; k < 4; k++) begin
      wr(`EIC_OFS_RPEDG, (k / 2) << (k % 2));
      wr(`EIC_OFS_RPFN, (k / 2) << (k % 2));
      request_pin_0_n <= k[0];
      request_pin_1_n <= ~k[0];
      repeat (6) @(posedge clock);
      wr(`EIC_OFS_FLG1, 0);
      wr(`EIC_OFS_RPFN, (1 - k / 2) << (k % 2));
      repeat (6) @(posedge clock);
      rchk(`EIC_OFS_FLG1, 1 << (k % 2));
      wr(`EIC_OFS_FLG1, 0);
    end
    // Event pin over every edge code, then once with its enable off
    for (k = 0; k < 5; k++) begin
      wr(`EIC_OFS_EVSEL, k % 4);
      wr(`EIC_OFS_ENA1, k < 4 ? 4 : 0);
      event_counter_request_pin <= 1'b1;
      repeat (6) @(posedge clock);
      rchk(`EIC_OFS_FLG1, (k < 4 && k != 0) ? 4 : 0);
      wr(`EIC_OFS_FLG1, 0);
      event_counter_request_pin <= 1'b0;
      repeat (6) @(posedge clock);
      rchk(`EIC_OFS_FLG1, (k < 4 && k != 1) ? 4 : 0);
      wr(`EIC_OFS_FLG1, 0);
    end
    // Odd stack pointer: the word writes must still land on even addresses
    core_sp      <= 16'($urandom) | 16'h0005;
    next_pc      <= 16'($urandom);
    cond_flags   <= 8'($urandom);
    m = 8'($urandom) | 8'h80;
    periph_req   <= m;
    sleep_dt_req <= 1'b1;
    @(posedge clock);
    periph_req   <= 8'h00;
    sleep_dt_req <= 1'b0;
    wr(`EIC_OFS_ENA1, 8'h10);
    wr(`EIC_OFS_ENA2, m);
    rchk(`EIC_OFS_FLG2, m);
    rchk(`EIC_OFS_FLG1, 8);
    check(req_out.valid, 0);
    check(req_out.idx, 8);
    wr(`EIC_OFS_CPU, 0);
    entry(8);
    wr(`EIC_OFS_FLG1, 32'hF7);
    core_rte <= 1'b1;
    @(posedge clock);
    core_rte <= 1'b0;
    @(posedge clock);
    check(i_mask, 0);
    for (k = 0; m[k] == 1'b0; k++) begin
    end
    entry(9 + k);
    rchk(`EIC_OFS_FLG2, m);
    conclude();
  end
endmodule
